// [pmrc_host.sv]
// host-side register port model for the power/rate control block
`timescale 1ns/1ns
`default_nettype none
module pmrc_host (
  // clock
  input  wire logic       clk_in,
  // register port
  output var  logic [7:0] addr_out,
  output var  logic       wr_out,
  output var  logic       rd_out,
  output var  logic [7:0] wdata_out,
  input  wire logic [7:0] rdata_in
);
  // idle port at time zero
  initial
  begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    wdata_out = 8'h00;
  end
  // all host activity sits a fixed delay after the rising edge
  task automatic step;
    @(posedge clk_in);
    #10;
  endtask : step
  // one-cycle write; leading idle cycle keeps strobes from merging
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step();
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    step();
    wr_out = 1'b0;
    addr_out = ~a; // stale values scrambled so they never help
    wdata_out = ~d;
  endtask : wr
  // one-cycle read; data is taken the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    step();
    addr_out = a;
    rd_out = 1'b1;
    step();
    rd_out = 1'b0;
    addr_out = ~a;
    d = rdata_in;
  endtask : rd
endmodule : pmrc_host
`default_nettype wire

// [pmrc_pkg.sv]
// package: register map, field positions, reset values and timing for power/rate control
package pmrc_pkg;

  // register offsets on the parallel register port
  localparam logic [7:0] RATE_CTRL_ADDR  = 8'h2C;
  localparam logic [7:0] POWER_CTRL_ADDR = 8'h2D;

  // field positions
  localparam int unsigned RATE_LSB      = 0;
  localparam int unsigned RATE_W        = 4;
  localparam int unsigned LOW_POWER_BIT = 4;
  localparam int unsigned MEASURE_BIT   = 3;

  // reset values
  localparam logic [7:0] RATE_CTRL_RST  = 8'h0A;
  localparam logic [7:0] POWER_CTRL_RST = 8'h00;
  localparam logic [7:0] READ_IDLE      = 8'h00;

  // timing: the fastest rate code gives the shortest output sample period
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned ODR_MAX_HZ   = 3200;
  localparam int unsigned ODR_BASE_CYC = CLK_HZ / ODR_MAX_HZ;
  localparam logic [3:0]  RATE_MAX     = 4'hF;
  localparam int unsigned CNT_W        = 27;

  // active sampling configuration
  typedef struct packed {
    logic       low_power;
    logic [3:0] rate;
  } pmrc_cfg_t;

  // operating mode, one-hot
  typedef enum logic [1:0] {
    PM_STANDBY = 2'b01,
    PM_MEASURE = 2'b10
  } pmrc_mode_t;

endpackage : pmrc_pkg

// [pmrc_tb_top.sv]
// self-checking bench for the power/rate control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) \
  begin \
    checks++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("BAD %0t got %0h expected %0h", $time, g, e); \
    end \
  end
module pmrc_tb_top;
  localparam int BASE = 4; // shortened base period keeps the run brief
  logic       clk_in = 1'b0;
  logic       rst_b_in = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, cfg;
  logic       reg_wr, reg_rd, measuring, low_power, sample_tick, odr_tick;
  logic [3:0] active_rate;
  int         fails = 0;
  int         checks = 0;
  int         cyc = 0;
  int         n, len, smp;
  ////////////////////////////////////////////////////////////////////////////
  always #50 clk_in = ~clk_in;
  // watchdog: the whole sequence needs well under this many cycles
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fails++;
      end_of_test();
    end
  end
  pmrc_host pmrc_host_inst (.clk_in(clk_in), .addr_out(reg_addr), .wr_out(reg_wr),
    .rd_out(reg_rd), .wdata_out(reg_wdata), .rdata_in(reg_rdata));
  pmrc_top #(.ODR_BASE_CYC(pmrc_pkg::CNT_W'(BASE))) pmrc_top_inst (.clk_in(clk_in),
    .rst_b_in(rst_b_in), .reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata), .measuring_out(measuring),
    .active_rate_out(active_rate), .low_power_out(low_power),
    .sample_tick_out(sample_tick), .odr_tick_out(odr_tick));
  // count steps up to the next sample or output tick
  task automatic to_tick(input logic odr, output int k);
    k = 0;
    do
    begin
      pmrc_host_inst.step();
      k++;
    end
    while ((odr ? odr_tick : sample_tick) !== 1'b1);
  endtask : to_tick
  task automatic end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (6) @(posedge clk_in);
    #10;
    `CHK({measuring, sample_tick, odr_tick}, 3'b000)
    rst_b_in = 1'b1;
    pmrc_host_inst.step();
    `CHK(active_rate, 4'hA)
    pmrc_host_inst.rd(pmrc_pkg::RATE_CTRL_ADDR, d);
    `CHK(d, pmrc_pkg::RATE_CTRL_RST)
    pmrc_host_inst.rd(pmrc_pkg::POWER_CTRL_ADDR, d);
    `CHK(d, pmrc_pkg::POWER_CTRL_RST)
    pmrc_host_inst.rd(8'h00, d);
    `CHK(d, pmrc_pkg::READ_IDLE)
    repeat (20)
    begin
      pmrc_host_inst.step();
      `CHK({measuring, sample_tick, odr_tick}, 3'b000)
    end
    $display("test standby done");
    pmrc_host_inst.wr(pmrc_pkg::RATE_CTRL_ADDR, 8'h0F);
    pmrc_host_inst.step();
    `CHK(active_rate, 4'hF)
    pmrc_host_inst.wr(pmrc_pkg::POWER_CTRL_ADDR, 8'h08);
    `CHK(measuring, 1'b0)
    pmrc_host_inst.step();
    `CHK(measuring, 1'b1)
    to_tick(1'b0, n);
    `CHK(n, BASE >> 1)
    `CHK(odr_tick, 1'b0)
    $display("test measure start done");
    // normal mode codes F..8, then reduced power only over codes C..7
    for (int i = 0; i < 14; i++)
    begin
      cfg = (i < 8) ? 8'(15 - i) : 8'(36 - i);
      len = BASE << (15 - cfg[3:0]);
      smp = cfg[4] ? len : len >> 1;
      to_tick(1'b1, n);
      pmrc_host_inst.wr(pmrc_pkg::RATE_CTRL_ADDR, cfg);
      pmrc_host_inst.step();
      `CHK(active_rate, (i == 0) ? 4'hF : ((i <= 8) ? 4'(16 - i) : 4'(37 - i)))
      to_tick(1'b1, n);
      to_tick(1'b0, n);
      `CHK(n, smp)
      `CHK(odr_tick, cfg[4])
      `CHK(active_rate, cfg[3:0])
      `CHK(low_power, cfg[4])
      to_tick(1'b1, n);
      `CHK(n, cfg[4] ? len : len - smp)
    end
    $display("test rate table done");
    to_tick(1'b1, n);
    pmrc_host_inst.wr(pmrc_pkg::POWER_CTRL_ADDR, 8'h00);
    `CHK(measuring, 1'b1)
    to_tick(1'b1, n);
    `CHK(n, len - 2)
    `CHK(measuring, 1'b0)
    pmrc_host_inst.step();
    `CHK(measuring, 1'b0)
    pmrc_host_inst.wr(pmrc_pkg::RATE_CTRL_ADDR, 8'h0B);
    pmrc_host_inst.wr(8'h2E, 8'hFF);
    pmrc_host_inst.step();
    `CHK(active_rate, 4'hB)
    pmrc_host_inst.rd(pmrc_pkg::RATE_CTRL_ADDR, d);
    `CHK(d, 8'h0B)
    pmrc_host_inst.rd(pmrc_pkg::POWER_CTRL_ADDR, d);
    `CHK(d, 8'h00)
    pmrc_host_inst.rd(8'h2E, d);
    `CHK(d, pmrc_pkg::READ_IDLE)
    $display("test standby return done");
    end_of_test();
  end
endmodule : pmrc_tb_top
`default_nettype wire

// [pmrc_top.sv]
// module: standby/measure sequencing and output-data-rate timing for the sensor core
`timescale 1ns/1ns
`default_nettype none
module pmrc_top #(
  parameter logic [pmrc_pkg::CNT_W-1:0] ODR_BASE_CYC = pmrc_pkg::CNT_W'(pmrc_pkg::ODR_BASE_CYC)
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // register port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  // sensor core control
  output logic            measuring_out,
  output logic      [3:0] active_rate_out,
  output logic            low_power_out,
  output logic            sample_tick_out,
  output logic            odr_tick_out
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // internal sampling period in clocks for a configuration
  function automatic logic [pmrc_pkg::CNT_W-1:0] f_period(
    input logic [pmrc_pkg::CNT_W-1:0] base,
    input pmrc_pkg::pmrc_cfg_t        cfg
  );
    logic [pmrc_pkg::CNT_W-1:0] odr;
    odr = base << (pmrc_pkg::RATE_MAX - cfg.rate);
    // normal mode samples twice per output, reduced power once
    f_period = cfg.low_power ? odr : (odr >> 1);
  endfunction : f_period

  // output sample length in clocks (two internal periods in normal mode)
  function automatic logic [pmrc_pkg::CNT_W-1:0] f_odr_len(
    input logic [pmrc_pkg::CNT_W-1:0] base,
    input pmrc_pkg::pmrc_cfg_t        cfg
  );
    logic [pmrc_pkg::CNT_W-1:0] p;
    p = f_period(base, cfg);
    f_odr_len = cfg.low_power ? p : (p << 1);
  endfunction : f_odr_len

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic [7:0] rate_reg;
  logic [7:0] rate_next;
  logic [7:0] pwr_reg;
  logic [7:0] pwr_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  pmrc_pkg::pmrc_cfg_t req_cfg;
  logic                meas_req;

  // writes land in any mode, so the host can configure while idle
  always_comb
  begin
    rate_next  = rate_reg;
    pwr_next   = pwr_reg;
    rdata_next = rdata_reg;
    if (reg_wr_in && (reg_addr_in == pmrc_pkg::RATE_CTRL_ADDR))
      rate_next = reg_wdata_in;
    if (reg_wr_in && (reg_addr_in == pmrc_pkg::POWER_CTRL_ADDR))
      pwr_next = reg_wdata_in;
    if (reg_rd_in)
    begin
      unique case (reg_addr_in)
        pmrc_pkg::RATE_CTRL_ADDR:  rdata_next = rate_reg;
        pmrc_pkg::POWER_CTRL_ADDR: rdata_next = pwr_reg;
        default:                   rdata_next = pmrc_pkg::READ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rate_reg  <= pmrc_pkg::RATE_CTRL_RST;
      pwr_reg   <= pmrc_pkg::POWER_CTRL_RST;
      rdata_reg <= pmrc_pkg::READ_IDLE;
    end
    else
    begin
      rate_reg  <= rate_next;
      pwr_reg   <= pwr_next;
      rdata_reg <= rdata_next;
    end
  end

  // requested settings as the host last wrote them
  assign req_cfg.low_power = rate_reg[pmrc_pkg::LOW_POWER_BIT];
  assign req_cfg.rate      = rate_reg[pmrc_pkg::RATE_LSB +: pmrc_pkg::RATE_W];
  assign meas_req          = pwr_reg[pmrc_pkg::MEASURE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // mode and sample timing

  pmrc_pkg::pmrc_mode_t       mode_reg;
  pmrc_pkg::pmrc_mode_t       mode_next;
  pmrc_pkg::pmrc_cfg_t        cfg_reg;
  pmrc_pkg::pmrc_cfg_t        cfg_next;
  logic [pmrc_pkg::CNT_W-1:0] cnt_reg;
  logic [pmrc_pkg::CNT_W-1:0] cnt_next;
  logic                       phase_reg;
  logic                       phase_next;
  logic                       stick_reg;
  logic                       stick_next;
  logic                       otick_reg;
  logic                       otick_next;

  // settings follow the request in standby and are latched in measure only at an output boundary so no partial sample escapes
  always_comb
  begin
    mode_next  = mode_reg;
    cfg_next   = cfg_reg;
    cnt_next   = cnt_reg;
    phase_next = phase_reg;
    stick_next = 1'b0;
    otick_next = 1'b0;
    unique case (mode_reg)
      pmrc_pkg::PM_STANDBY:
      begin
        cfg_next = req_cfg;
        if (meas_req)
        begin
          mode_next  = pmrc_pkg::PM_MEASURE;
          cnt_next   = f_period(ODR_BASE_CYC, req_cfg) - 1'b1;
          phase_next = 1'b0;
        end
      end
      pmrc_pkg::PM_MEASURE:
      begin
        if (cnt_reg == '0)
        begin
          stick_next = 1'b1;
          if (cfg_reg.low_power || phase_reg)
          begin
            otick_next = 1'b1;
            phase_next = 1'b0;
            cfg_next   = req_cfg;
            cnt_next   = f_period(ODR_BASE_CYC, req_cfg) - 1'b1;
            if (!meas_req)
              mode_next = pmrc_pkg::PM_STANDBY;
          end
          else
          begin
            phase_next = 1'b1;
            cnt_next   = f_period(ODR_BASE_CYC, cfg_reg) - 1'b1;
          end
        end
        else
          cnt_next = cnt_reg - 1'b1;
      end
    endcase
  end

  // power-up lands in standby with the counter idle
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      mode_reg  <= pmrc_pkg::PM_STANDBY;
      cfg_reg   <= '0;
      cnt_reg   <= '0;
      phase_reg <= 1'b0;
      stick_reg <= 1'b0;
      otick_reg <= 1'b0;
    end
    else
    begin
      mode_reg  <= mode_next;
      cfg_reg   <= cfg_next;
      cnt_reg   <= cnt_next;
      phase_reg <= phase_next;
      stick_reg <= stick_next;
      otick_reg <= otick_next;
    end
  end

  // outputs come straight from flops, except measuring_out, decoded from mode_reg
  assign reg_rdata_out   = rdata_reg;
  assign measuring_out   = (mode_reg == pmrc_pkg::PM_MEASURE);
  assign active_rate_out = cfg_reg.rate;
  assign low_power_out   = cfg_reg.low_power;
  assign sample_tick_out = stick_reg;
  assign odr_tick_out    = otick_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // gap counter between output ticks, only read by the checks
  // a counter is used because a long tick spacing cannot be unrolled by the tools
  logic [pmrc_pkg::CNT_W-1:0] gap_reg;
  logic                       gap_ok_reg;
  pmrc_pkg::pmrc_cfg_t        gap_cfg_reg;
  logic                       mid_seen_reg;
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      gap_reg      <= '0;
      gap_ok_reg   <= 1'b0;
      gap_cfg_reg  <= '0;
      mid_seen_reg <= 1'b0;
    end
    else if (!measuring_out)
    begin
      gap_reg      <= '0;
      gap_ok_reg   <= 1'b0;
      mid_seen_reg <= 1'b0;
    end
    else if (odr_tick_out)
    begin
      gap_reg      <= {{(pmrc_pkg::CNT_W-1){1'b0}}, 1'b1};
      gap_ok_reg   <= 1'b1;
      gap_cfg_reg  <= cfg_reg;
      mid_seen_reg <= 1'b0;
    end
    else
    begin
      gap_reg <= gap_reg + 1'b1;
      if (sample_tick_out)
        mid_seen_reg <= 1'b1; // internal sample inside the output period
    end
  end

  AST_STANDBY_HOLDS: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (!measuring_out && !meas_req) |=> !measuring_out && !sample_tick_out)
    else $error("core left standby without a measure request");

  AST_MEASURE_START: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (!measuring_out && meas_req) |=> measuring_out)
    else $error("measure request did not start measurement");

  AST_POWER_WRITE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (reg_wr_in && reg_addr_in == pmrc_pkg::POWER_CTRL_ADDR) |=> pwr_reg == $past(reg_wdata_in))
    else $error("power_control write lost");

  AST_RATE_READBACK: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (reg_rd_in && reg_addr_in == pmrc_pkg::RATE_CTRL_ADDR) |=> reg_rdata_out == $past(rate_reg))
    else $error("output_rate_control read wrong");

  AST_MEASURE_STOP: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (odr_tick_out && !$past(meas_req)) |-> !measuring_out)
    else $error("cleared measure bit did not return to standby at boundary");

  AST_STOP_AT_BOUNDARY: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ($past(measuring_out) && !measuring_out) |-> odr_tick_out)
    else $error("measurement stopped inside an output sample");

  AST_LOW_POWER_ONE_SAMPLE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (sample_tick_out && $past(cfg_reg.low_power) && $past(measuring_out)) |-> odr_tick_out)
    else $error("reduced power internal sample not aligned to output");

  AST_NORMAL_TWO_SAMPLES: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (odr_tick_out && gap_ok_reg && !gap_cfg_reg.low_power) |-> mid_seen_reg)
    else $error("normal mode output tick without intermediate sample");

  AST_ODR_SPACING: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (odr_tick_out && gap_ok_reg) |-> gap_reg == f_odr_len(ODR_BASE_CYC, gap_cfg_reg))
    else $error("output sample spacing does not match rate code");

  AST_CFG_AT_BOUNDARY: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ($past(measuring_out) && measuring_out && cfg_reg != $past(cfg_reg)) |-> odr_tick_out)
    else $error("configuration changed inside an output sample");

endmodule : pmrc_top
`default_nettype wire
